//--- hdl/two_wire_slave_pkg.sv
// Constants, register map and types shared by the two-wire slave transmitter.
package two_wire_slave_pkg;

  localparam int unsigned AXI_AW = 5;
  localparam int unsigned AXI_DW = 32;

  // Register indices; the byte address is four times the index.
  localparam logic [2:0] IDX_STATUS = 3'h1;
  localparam logic [2:0] IDX_OWN    = 3'h2;
  localparam logic [2:0] IDX_DATA   = 3'h3;
  localparam logic [2:0] IDX_CTRL   = 3'h4;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [7:0] DATA_RST      = 8'hFF;
  localparam logic [7:0] OWN_RST       = 8'h00;
  localparam logic [6:0] GCALL_ADDR    = 7'h00;
  localparam int unsigned STATUS_CODES = 26;

  localparam logic [7:0] CODE_NONE      = 8'hF8;
  localparam logic [7:0] CODE_BUS_ERR   = 8'h00;
  localparam logic [7:0] CODE_OWN_RD     = 8'hA8;
  localparam logic [7:0] CODE_ARB_OWN_RD = 8'hB0;
  localparam logic [7:0] CODE_TX_ACK    = 8'hB8;
  localparam logic [7:0] CODE_TX_NACK   = 8'hC0;
  localparam logic [7:0] CODE_LAST_ACK  = 8'hC8;

  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] CNT_ZERO  = 4'h0;
  localparam logic [3:0] CNT_ONE   = 4'h1;

  // Control register layout, bit 7 down to bit 0.
  typedef struct packed {
    logic flag;
    logic ack_en;
    logic start;
    logic stop;
    logic wcol;
    logic en;
    logic rsv;
    logic ie;
  } ctl_t;

  localparam ctl_t CTL_RST = '0;

  // Status register: code in bits 7..3, bits 2..0 read as zero.
  typedef struct packed {
    logic [4:0] code;
    logic [2:0] rsv;
  } status_t;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_ADDR     = 3'b001,
    ST_ADDR_ACK = 3'b010,
    ST_WAIT     = 3'b011,
    ST_TX_BIT   = 3'b100,
    ST_TX_ACK   = 3'b101,
    ST_IGNORE   = 3'b110
  } st_t;

endpackage : two_wire_slave_pkg

//--- hdl/two_wire_slave_tx.sv
// Two-wire slave transmitter with status, data and control registers on AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module two_wire_slave_tx
  import two_wire_slave_pkg::*;
(
  input  wire logic                              mclk,
  input  wire logic                              rst,
  input  wire logic [two_wire_slave_pkg::AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                              s_axi_awvalid,
  output logic                                   s_axi_awready,
  input  wire logic [two_wire_slave_pkg::AXI_DW-1:0] s_axi_wdata,
  input  wire logic [3:0]                        s_axi_wstrb,
  input  wire logic                              s_axi_wvalid,
  output logic                                   s_axi_wready,
  output logic [1:0]                             s_axi_bresp,
  output logic                                   s_axi_bvalid,
  input  wire logic                              s_axi_bready,
  input  wire logic [two_wire_slave_pkg::AXI_AW-1:0] s_axi_araddr,
  input  wire logic                              s_axi_arvalid,
  output logic                                   s_axi_arready,
  output logic [two_wire_slave_pkg::AXI_DW-1:0]  s_axi_rdata,
  output logic [1:0]                             s_axi_rresp,
  output logic                                   s_axi_rvalid,
  input  wire logic                              s_axi_rready,
  input  wire logic                              global_irq_enable,
  input  wire logic                              arb_lost,
  output logic                                   irq,
  input  wire logic                              scl_i,
  output logic                                   scl_o,
  output logic                                   scl_oe_n,
  input  wire logic                              sda_i,
  output logic                                   sda_o,
  output logic                                   sda_oe_n
);
  import two_wire_slave_pkg::*;

  ctl_t                 ctl_ff;
  status_t              status_ff;
  logic [7:0]           data_ff;
  logic [7:0]           own_ff;
  logic [7:0]           code_ff;
  st_t                  st_ff;
  logic [3:0]           cnt_ff;
  logic [7:0]           shift_ff;
  logic [7:0]           rx_ff;
  logic                 last_ff;
  logic                 ack_seen_ff;
  logic                 arb_ff;
  logic                 irq_ff;
  logic                 scl_oe_n_ff;
  logic                 sda_oe_n_ff;
  logic [2:0]           scl_sync_ff;
  logic [2:0]           sda_sync_ff;
  logic                 have_aw_ff;
  logic                 have_w_ff;
  logic [AXI_AW-1:0]    awaddr_ff;
  logic [AXI_DW-1:0]    wdata_ff;
  logic [3:0]           wstrb_ff;
  logic                 awready_ff;
  logic                 wready_ff;
  logic                 bvalid_ff;
  logic [1:0]           bresp_ff;
  logic                 arready_ff;
  logic                 rvalid_ff;
  logic [1:0]           rresp_ff;
  logic [AXI_DW-1:0]    rdata_ff;

  logic                 scl_rise;
  logic                 scl_fall;
  logic                 bus_start;
  logic                 bus_stop;
  logic                 wr_fire;
  logic [2:0]           wr_idx;
  logic                 wr_lane0;
  logic                 data_wr_req;
  logic                 ctl_wr;
  logic                 flag_clr;
  logic                 hw_set;
  logic [7:0]           hw_code;
  logic                 in_frame;
  logic                 addr_hit;
  logic                 recover;
  logic [2:0]           rd_idx;

  // Pins pass three flip-flops; edge logic reads only the second and third stage.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      scl_sync_ff <= 3'h7;
      sda_sync_ff <= 3'h7;
    end else begin
      scl_sync_ff <= {scl_sync_ff[1:0], scl_i};
      sda_sync_ff <= {sda_sync_ff[1:0], sda_i};
    end
  end

  assign scl_rise  = scl_sync_ff[1] & ~scl_sync_ff[2];
  assign scl_fall  = ~scl_sync_ff[1] & scl_sync_ff[2];
  assign bus_start = scl_sync_ff[1] & scl_sync_ff[2] & ~sda_sync_ff[1] & sda_sync_ff[2];
  assign bus_stop  = scl_sync_ff[1] & scl_sync_ff[2] & sda_sync_ff[1] & ~sda_sync_ff[2];

  // AXI4-Lite write channel: address and data are taken in either order.
  assign wr_fire     = have_aw_ff & have_w_ff & ~bvalid_ff;
  assign wr_idx      = awaddr_ff[4:2];
  assign wr_lane0    = wstrb_ff[0];
  assign ctl_wr      = wr_fire & wr_lane0 & (wr_idx == IDX_CTRL);
  assign data_wr_req = wr_fire & wr_lane0 & (wr_idx == IDX_DATA);
  assign flag_clr    = ctl_wr & wdata_ff[7];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      have_aw_ff <= 1'b0;
      have_w_ff  <= 1'b0;
      awaddr_ff  <= '0;
      wdata_ff   <= '0;
      wstrb_ff   <= '0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awready_ff) begin
        have_aw_ff <= 1'b1;
        awaddr_ff  <= s_axi_awaddr;
        awready_ff <= 1'b0;
      end else if (!have_aw_ff && !bvalid_ff) begin
        awready_ff <= 1'b1;
      end
      if (s_axi_wvalid && wready_ff) begin
        have_w_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata;
        wstrb_ff  <= s_axi_wstrb;
        wready_ff <= 1'b0;
      end else if (!have_w_ff && !bvalid_ff) begin
        wready_ff <= 1'b1;
      end
      if (wr_fire) begin
        have_aw_ff <= 1'b0;
        have_w_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= (wr_idx == IDX_CTRL || wr_idx == IDX_DATA || wr_idx == IDX_OWN ||
                       wr_idx == IDX_STATUS) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channel; the answer comes one cycle after the address is taken.
  assign rd_idx = s_axi_araddr[4:2];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rresp_ff   <= RESP_OKAY;
      rdata_ff   <= '0;
    end else if (rvalid_ff) begin
      if (s_axi_rready) begin
        rvalid_ff  <= 1'b0;
        arready_ff <= 1'b1;
      end
    end else if (s_axi_arvalid && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b1;
      rresp_ff   <= RESP_OKAY;
      rdata_ff   <= '0;
      unique case (rd_idx)
        IDX_STATUS: rdata_ff[7:0] <= status_ff;
        IDX_OWN:    rdata_ff[7:0] <= own_ff;
        IDX_DATA:   rdata_ff[7:0] <= data_ff;
        IDX_CTRL:   rdata_ff[7:0] <= ctl_ff;
        default:    rresp_ff      <= RESP_SLVERR;
      endcase
    end else begin
      arready_ff <= 1'b1;
    end
  end

  // Own address register: address in bits 7..1, general call enable in bit 0.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      own_ff <= OWN_RST;
    end else if (wr_fire && wr_lane0 && wr_idx == IDX_OWN) begin
      own_ff <= wdata_ff[7:0];
    end
  end

  // Own address, data and control registers are writable; status ignores writes.
  assign in_frame = (st_ff == ST_ADDR && cnt_ff != CNT_ZERO) || st_ff == ST_ADDR_ACK ||
                    st_ff == ST_TX_BIT || st_ff == ST_TX_ACK;
  assign addr_hit = ctl_ff.ack_en && ctl_ff.en && rx_ff[0] &&
                    (rx_ff[7:1] == own_ff[7:1] ||
                     (own_ff[0] && rx_ff[7:1] == GCALL_ADDR));
  assign recover  = st_ff == ST_WAIT && !ctl_ff.flag && code_ff == CODE_BUS_ERR;

  // Hardware flag set and the code it reports.
  always_comb begin
    hw_set  = 1'b0;
    hw_code = code_ff;
    if (in_frame && (bus_start || bus_stop)) begin
      hw_set  = 1'b1;
      hw_code = CODE_BUS_ERR;
    end else if (st_ff == ST_ADDR_ACK && scl_fall) begin
      hw_set  = 1'b1;
      hw_code = arb_ff ? CODE_ARB_OWN_RD : CODE_OWN_RD;
    end else if (st_ff == ST_TX_ACK && scl_fall) begin
      hw_set  = 1'b1;
      hw_code = !ack_seen_ff ? CODE_TX_NACK : last_ff ? CODE_LAST_ACK : CODE_TX_ACK;
    end
  end

  // Control register; a hardware set of the flag wins over a software clear.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctl_ff <= CTL_RST;
    end else begin
      if (ctl_wr) begin
        ctl_ff.ack_en <= wdata_ff[6];
        ctl_ff.start  <= wdata_ff[5];
        ctl_ff.stop   <= wdata_ff[4];
        ctl_ff.en     <= wdata_ff[2];
        ctl_ff.ie     <= wdata_ff[0];
      end
      if (hw_set) begin
        ctl_ff.flag <= 1'b1;
      end else if (flag_clr) begin
        ctl_ff.flag <= 1'b0;
      end
      if (data_wr_req && !ctl_ff.flag) begin
        ctl_ff.wcol <= 1'b1;
      end else if (data_wr_req) begin
        ctl_ff.wcol <= 1'b0;
      end
      if (recover && ctl_ff.stop) begin
        ctl_ff.stop <= 1'b0;
      end
      ctl_ff.rsv <= 1'b0;
    end
  end

  // Status follows the flag with one clock of lag in both directions.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      status_ff <= CODE_NONE;
      code_ff   <= CODE_NONE;
    end else begin
      if (hw_set) begin
        code_ff <= hw_code;
      end
      status_ff <= ctl_ff.flag ? {code_ff[7:3], 3'b000} : CODE_NONE;
    end
  end

  // Data register: software writes only while the flag is set, hardware only while clear.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      data_ff <= DATA_RST;
    end else if (data_wr_req && ctl_ff.flag) begin
      data_ff <= wdata_ff[7:0];
    end else if (!ctl_ff.flag && hw_set && hw_code != CODE_BUS_ERR) begin
      data_ff <= rx_ff;
    end
  end

  // Arbitration loss from the master side is remembered until the next hardware flag set or an ignored address.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      arb_ff <= 1'b0;
    end else if (arb_lost) begin
      arb_ff <= 1'b1;
    end else if (hw_set || st_ff == ST_IGNORE) begin
      arb_ff <= 1'b0;
    end
  end

  // Bus sequencer: address phase, acknowledge, byte transmission and waiting on software.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_ff       <= ST_IDLE;
      cnt_ff      <= CNT_ZERO;
      shift_ff    <= DATA_RST;
      rx_ff       <= DATA_RST;
      last_ff     <= 1'b0;
      ack_seen_ff <= 1'b0;
    end else if (!ctl_ff.en) begin
      st_ff <= ST_IDLE;
    end else if (in_frame && (bus_start || bus_stop)) begin
      st_ff <= ST_WAIT;
    end else begin
      unique case (st_ff)
        ST_IDLE, ST_IGNORE: begin
          if (bus_start) begin
            st_ff  <= ST_ADDR;
            cnt_ff <= CNT_ZERO;
          end else if (bus_stop) begin
            st_ff <= ST_IDLE;
          end
        end
        ST_ADDR: begin
          if (bus_start) begin
            cnt_ff <= CNT_ZERO;
          end else if (bus_stop) begin
            st_ff <= ST_IDLE;
          end else if (scl_rise && cnt_ff != BYTE_BITS) begin
            rx_ff  <= {rx_ff[6:0], sda_sync_ff[1]};
            cnt_ff <= cnt_ff + CNT_ONE;
          end else if (scl_fall && cnt_ff == BYTE_BITS) begin
            st_ff <= addr_hit ? ST_ADDR_ACK : ST_IGNORE;
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            st_ff <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (!ctl_ff.flag) begin
            if (code_ff == CODE_OWN_RD || code_ff == CODE_ARB_OWN_RD ||
                code_ff == CODE_TX_ACK) begin
              st_ff    <= ST_TX_BIT;
              cnt_ff   <= CNT_ZERO;
              shift_ff <= data_ff;
              last_ff  <= !ctl_ff.ack_en;
            end else begin
              st_ff <= ST_IDLE;
            end
          end
        end
        ST_TX_BIT: begin
          if (scl_rise) begin
            rx_ff  <= {rx_ff[6:0], sda_sync_ff[1]};
            cnt_ff <= cnt_ff + CNT_ONE;
          end else if (scl_fall) begin
            if (cnt_ff == BYTE_BITS) begin
              st_ff <= ST_TX_ACK;
            end else begin
              shift_ff <= {shift_ff[6:0], 1'b1};
            end
          end
        end
        ST_TX_ACK: begin
          if (scl_rise) begin
            ack_seen_ff <= !sda_sync_ff[1];
          end else if (scl_fall) begin
            st_ff <= ST_WAIT;
          end
        end
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  // Line drivers: an enable low pulls the open-drain line low.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      scl_oe_n_ff <= 1'b1;
      sda_oe_n_ff <= 1'b1;
    end else begin
      // The hold lasts until the sequencer leaves the wait, so the clock is let go no
      // earlier than the first data bit reaches the line.
      scl_oe_n_ff <= !(st_ff == ST_WAIT && code_ff != CODE_BUS_ERR &&
                       code_ff != CODE_TX_NACK && code_ff != CODE_LAST_ACK);
      unique case (st_ff)
        ST_ADDR_ACK: sda_oe_n_ff <= 1'b0;
        // The last bit stays on the line until the clock falls; letting go while the
        // clock is high would put a stop condition on the bus.
        ST_TX_BIT:   sda_oe_n_ff <= shift_ff[7];
        default:     sda_oe_n_ff <= 1'b1;
      endcase
    end
  end

  // Interrupt request held as a level while the flag stays set.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= ctl_ff.flag & ctl_ff.ie & global_irq_enable;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rresp   = rresp_ff;
  assign s_axi_rdata   = rdata_ff;
  assign irq           = irq_ff;
  assign scl_oe_n      = scl_oe_n_ff;
  assign sda_oe_n      = sda_oe_n_ff;
  assign scl_o         = 1'b0;
  assign sda_o         = 1'b0;

  irq_level_a: assert property (@(posedge mclk) disable iff (rst)
    (ctl_ff.flag && ctl_ff.ie && global_irq_enable) |=> irq_ff)
    else $error("irq not raised while flag and enables set");
  idle_code_a: assert property (@(posedge mclk) disable iff (rst)
    !ctl_ff.flag |=> (status_ff == CODE_NONE && !irq_ff))
    else $error("status not F8 or irq set while flag clear");
  status_zero_a: assert property (@(posedge mclk) disable iff (rst)
    status_ff[2:0] == 3'b000)
    else $error("status low bits not zero");
  status_lag_a: assert property (@(posedge mclk) disable iff (rst)
    $rose(ctl_ff.flag) |-> (status_ff == CODE_NONE) ##1 (status_ff == code_ff))
    else $error("status did not follow flag by one clock");
  data_hold_a: assert property (@(posedge mclk) disable iff (rst)
    (ctl_ff.flag && !data_wr_req) |=> $stable(data_ff))
    else $error("data changed by hardware while flag set");
  collision_a: assert property (@(posedge mclk) disable iff (rst)
    (data_wr_req && !ctl_ff.flag) |=> (ctl_ff.wcol && $stable(data_ff)))
    else $error("write collision not flagged");
  bus_error_a: assert property (@(posedge mclk) disable iff (rst)
    (ctl_ff.en && in_frame && (bus_start || bus_stop)) |=>
      (ctl_ff.flag && code_ff == CODE_BUS_ERR && st_ff == ST_WAIT))
    else $error("bus error not reported");
  recovery_a: assert property (@(posedge mclk) disable iff (rst)
    (recover && ctl_ff.stop && ctl_ff.en) |=> (!ctl_ff.stop && st_ff == ST_IDLE) ##1 sda_oe_n_ff)
    else $error("bus error recovery wrong");
  stretch_a: assert property (@(posedge mclk) disable iff (rst)
    (st_ff == ST_WAIT && ctl_ff.flag && code_ff == CODE_TX_ACK) |=> !scl_oe_n_ff)
    else $error("clock not held while waiting on software");
  ignore_a: assert property (@(posedge mclk) disable iff (rst)
    (st_ff == ST_IGNORE) [*2] |-> sda_oe_n_ff)
    else $error("unaddressed slave drives data line");

endmodule : two_wire_slave_tx
`default_nettype wire

//--- tb/link_master.sv
// Behavioural two-wire master receiver on the far side of the link.
`timescale 1ns/10ps
`default_nettype none
module link_master (
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_drv,
  output logic      sda_drv
);
  logic ack;
  initial scl_drv = 1'b1;
  initial sda_drv = 1'b1;
  task automatic xfer(input logic b, output logic s);
    sda_drv = b;
    #400;
    scl_drv = 1'b1;
    wait (scl === 1'b1);
    s = sda;
    #400;
    scl_drv = 1'b0;
  endtask : xfer
  task automatic cond(input logic stop);
    sda_drv = !stop;
    #400;
    scl_drv = 1'b1;
    wait (scl === 1'b1);
    #400;
    sda_drv = stop;
    #400;
    scl_drv = stop;
  endtask : cond
  task automatic byte_io(input logic [7:0] o, input int n, input logic a, output logic [7:0] g);
    for (int i = 0; i < n; i++) begin
      xfer(o[7-i], g[7-i]);
    end
    xfer(a, ack);
  endtask : byte_io
endmodule : link_master
`default_nettype wire

//--- tb/two_wire_slave_tx_status_data_bench.sv
// Register-level bench driving AXI4-Lite software calls against a link master.
`timescale 1ns/10ps
`default_nettype none
module two_wire_slave_tx_status_data_bench;
  import two_wire_slave_pkg::*;
  localparam logic [4:0] A_ST  = {IDX_STATUS, 2'b00};
  localparam logic [4:0] A_OWN = {IDX_OWN, 2'b00};
  localparam logic [4:0] A_DT  = {IDX_DATA, 2'b00};
  localparam logic [4:0] A_CT  = {IDX_CTRL, 2'b00};
  logic        mclk = 1'b0, rst = 1'b1, arb_lost = 1'b0, global_irq_enable = 1'b1;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [4:0]  s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic        scl_o, scl_oe_n, sda_o, sda_oe_n, m_scl, m_sda;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [7:0]  v, d;
  int          miscompares = 0, n_checks = 0;
  wire logic   scl = m_scl & (scl_oe_n | scl_o);
  wire logic   sda = m_sda & (sda_oe_n | sda_o);
  two_wire_slave_tx DUT (
    .mclk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .global_irq_enable, .arb_lost, .irq, .scl_i(scl), .scl_o, .scl_oe_n, .sda_i(sda), .sda_o,
    .sda_oe_n);
  link_master m (.scl, .sda, .scl_drv(m_scl), .sda_drv(m_sda));
  initial forever #50 mclk = ~mclk;
  task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] x);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= {24'h000000, x};
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (w ? !s_axi_bvalid : !s_axi_rvalid);
    v = s_axi_rdata[7:0];
    r = w ? s_axi_bresp : s_axi_rresp;
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
  endtask : acc
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Codes C0 and C8 (bit 6 set) release the clock, as does 00; A8, B0 and B8 hold it low.
  task automatic serve(input logic [7:0] code, input logic [7:0] seen, input logic [7:0] nxt,
                       input logic [7:0] ctl);
    do acc(1'b0, A_CT, 8'h00); while (v[7] !== 1'b1);
    chk("irq", {7'h00, global_irq_enable}, {7'h00, irq});
    chk("clock hold", {7'h00, code[6]}, {7'h00, scl_oe_n});
    acc(1'b0, A_ST, 8'h00);
    chk("status", code, v);
    acc(1'b0, A_DT, 8'h00);
    chk("data", seen, v);
    acc(1'b1, A_DT, nxt);
    acc(1'b1, A_CT, ctl);
  endtask : serve
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up
  initial begin
    #3ms;
    miscompares++;
    wrap_up();
  end
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    acc(1'b0, 5'h14, 8'h00);
    chk("unmapped resp", {6'h00, RESP_SLVERR}, {6'h00, r});
    acc(1'b1, A_DT, 8'h12);
    acc(1'b0, A_CT, 8'h00);
    chk("collision", 8'h08, v);
    acc(1'b1, A_OWN, 8'hA0);
    acc(1'b1, A_CT, 8'h05);
    m.cond(1'b0);
    m.byte_io(8'hA1, 8, 1'b1, d);
    m.cond(1'b1);
    chk("ignored ack", 8'h01, {7'h00, m.ack});
    acc(1'b1, A_CT, 8'h45);
    arb_lost <= 1'b1;
    @(posedge mclk);
    arb_lost <= 1'b0;
    m.cond(1'b0);
    m.byte_io(8'hA1, 8, 1'b1, d);
    chk("addr ack", 8'h00, {7'h00, m.ack});
    serve(CODE_ARB_OWN_RD, 8'hA1, 8'h3C, 8'hC5);
    m.byte_io(8'hFF, 8, 1'b0, d);
    chk("byte one", 8'h3C, d);
    serve(CODE_TX_ACK, 8'h3C, 8'h5A, 8'h85);
    m.byte_io(8'hFF, 8, 1'b0, d);
    chk("byte two", 8'h5A, d);
    serve(CODE_LAST_ACK, 8'h5A, 8'h77, 8'h85);
    m.byte_io(8'hFF, 8, 1'b1, d);
    chk("after last", 8'hFF, d);
    m.cond(1'b1);
    acc(1'b0, A_ST, 8'h00);
    chk("idle status", CODE_NONE, v);
    acc(1'b1, A_CT, 8'h45);
    global_irq_enable <= 1'b0;
    m.cond(1'b0);
    m.byte_io(8'hA1, 8, 1'b1, d);
    serve(CODE_OWN_RD, 8'hA1, 8'hC3, 8'h85);
    m.byte_io(8'hFF, 8, 1'b1, d);
    chk("last byte", 8'hC3, d);
    serve(CODE_TX_NACK, 8'hC3, 8'h66, 8'hC5);
    m.cond(1'b1);
    m.cond(1'b0);
    m.byte_io(8'hA1, 3, 1'b1, d);
    m.cond(1'b1);
    do acc(1'b0, A_CT, 8'h00); while (v[7] !== 1'b1);
    acc(1'b0, A_ST, 8'h00);
    chk("bus error", CODE_BUS_ERR, v);
    chk("lines free", 8'h03, {6'h00, scl_oe_n, sda_oe_n});
    acc(1'b1, A_CT, 8'hD5);
    acc(1'b0, A_CT, 8'h00);
    chk("recovered", 8'h45, v);
    acc(1'b1, 5'h14, 8'h00);
    chk("unmapped bresp", {6'h00, RESP_SLVERR}, {6'h00, r});
    acc(1'b1, A_ST, 8'h00);
    chk("status bresp", {6'h00, RESP_OKAY}, {6'h00, r});
    acc(1'b0, A_ST, 8'h00);
    chk("status ro", CODE_NONE, v);
    s_axi_wstrb <= 4'hE;
    acc(1'b1, A_CT, 8'h00);
    s_axi_wstrb <= 4'hF;
    acc(1'b0, A_CT, 8'h00);
    chk("lane masked", 8'h45, v);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    acc(1'b0, A_DT, 8'h00);
    chk("reset data", DATA_RST, v);
    acc(1'b0, A_CT, 8'h00);
    chk("reset control", 8'h00, v);
    wrap_up();
  end
endmodule : two_wire_slave_tx_status_data_bench
`default_nettype wire
